// file: verilog/rxs_defs.svh
// offsets, field positions, reset values and limits of the receive status bank
`ifndef RXS_DEFS_SVH
`define RXS_DEFS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define RXS_ADDR_W        6
`define RXS_OFS_STATUS    6'h08
`define RXS_OFS_COUNT     6'h09
`define RXS_OFS_LENGTH    6'h0A

// ****************************************************************
// status register field positions
// ****************************************************************
`define RXS_BIT_ACK       7
`define RXS_BIT_MISMATCH  6
`define RXS_BIT_EARLY     5
`define RXS_BIT_ZSEED     4
`define RXS_BIT_BADCRC    3
`define RXS_BIT_CODE64    2
`define RXS_MODE_MSB      1
`define RXS_MODE_LSB      0

// ****************************************************************
// reset values and limits
// ****************************************************************
`define RXS_RST_STATUS    8'h00
`define RXS_RST_COUNT     8'h00
`define RXS_RST_LENGTH    8'h00
`define RXS_LEN_ERR_VALUE 8'h00
`define RXS_COUNT_MAX     8'hFF
`define RXS_COUNT_ONE     8'h01
`define RXS_MODE_GFSK     2'h0
`define RXS_RDATA_NONE    8'h00

`endif

// file: verilog/rxs_pkg.sv
// types shared by the receive status bank
`default_nettype none
package rxs_pkg;

  // receive sequence tracking states
  typedef enum logic [1:0] {
    RXS_IDLE,
    RXS_HDR,
    RXS_BODY,
    RXS_DONE
  } rxs_state_type;

  // data mode field of the status register
  typedef logic [1:0] rxs_mode_type;

endpackage
`default_nettype wire

// file: verilog/rxs_flags.sv
// packet status flags held in the receive status register
`timescale 1ns/1ps
`default_nettype none
`include "rxs_defs.svh"
module rxs_flags
  import rxs_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_sop,
  input  wire logic         i_type_load,
  input  wire logic         i_pkt_ack,
  input  wire logic         i_expect_ack,
  input  wire logic         i_early_set,
  input  wire logic         i_crc_load,
  input  wire logic         i_crc_bad,
  input  wire logic         i_zero_seed,
  input  wire logic         i_code64,
  input  wire logic         i_framed,
  input  wire rxs_mode_type i_mode,
  output logic [7:0]        o_status
);

  logic [7:0] status_r;
  logic [7:0] status_nxt;

  // each flag moves on its own event, so the byte is not atomic
  always_comb begin
    status_nxt = status_r;
    if (i_type_load) begin
      status_nxt[`RXS_BIT_ACK]      = i_pkt_ack;
      status_nxt[`RXS_BIT_MISMATCH] = i_pkt_ack ^ i_expect_ack;
    end
    // a new start clears the early end flag, but a set that lands in
    // the same cycle wins so the event is not lost
    if (i_sop) begin
      status_nxt[`RXS_BIT_EARLY] = 1'b0;
    end
    if (i_early_set) begin
      status_nxt[`RXS_BIT_EARLY] = 1'b1;
    end
    if (i_crc_load) begin
      status_nxt[`RXS_BIT_ZSEED]  = i_zero_seed;
      status_nxt[`RXS_BIT_BADCRC] = i_crc_bad;
      // code length and mode only follow a packet that checked good
      if (!i_crc_bad) begin
        status_nxt[`RXS_BIT_CODE64] = i_code64;
        if (i_framed) begin
          status_nxt[`RXS_MODE_MSB:`RXS_MODE_LSB] = i_mode;
        end
      end
    end
  end

  // register stage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      status_r <= `RXS_RST_STATUS;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign o_status = status_r;

endmodule // rxs_flags
`default_nettype wire

// file: verilog/rxs_count.sv
// payload byte counter and received length field
`timescale 1ns/1ps
`default_nettype none
`include "rxs_defs.svh"
module rxs_count
  import rxs_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_clear,
  input  wire logic       i_byte,
  input  wire logic       i_len_load,
  input  wire logic [7:0] i_len_value,
  output logic [7:0]      o_count,
  output logic [7:0]      o_length
);

  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic [7:0] length_r;
  logic [7:0] length_nxt;

  // counter saturates rather than wrapping; a byte in the clearing
  // cycle is counted as the first byte of the new packet
  always_comb begin
    count_nxt  = count_r;
    length_nxt = length_r;
    if (i_clear) begin
      count_nxt = i_byte ? `RXS_COUNT_ONE : `RXS_RST_COUNT;
    end else if (i_byte && (count_r != `RXS_COUNT_MAX)) begin
      count_nxt = count_r + `RXS_COUNT_ONE;
    end
    if (i_len_load) begin
      length_nxt = i_len_value;
    end
  end

  // register stage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count_r  <= `RXS_RST_COUNT;
      length_r <= `RXS_RST_LENGTH;
    end else begin
      count_r  <= count_nxt;
      length_r <= length_nxt;
    end
  end

  assign o_count  = count_r;
  assign o_length = length_r;

endmodule // rxs_count
`default_nettype wire

// file: verilog/rxs_regs.sv
// receive packet status register bank with its register port
`timescale 1ns/1ps
`default_nettype none
`include "rxs_defs.svh"

module rxs_regs
  import rxs_pkg::*;
(
  input  wire logic                   I_CLK,
  input  wire logic                   I_RST,
  // register port from the serial control engine
  input  wire logic [`RXS_ADDR_W-1:0] I_REG_ADDR,
  input  wire logic                   I_REG_RD,
  input  wire logic                   I_REG_WR,
  input  wire logic [7:0]             I_REG_WDATA,
  output logic [7:0]                  O_REG_RDATA,
  output logic                        O_REG_ACK,
  // receive datapath events
  input  wire logic                   I_LEN_EN,
  input  wire logic                   I_START_OF_PACKET,
  input  wire logic                   I_TYPE_VALID,
  input  wire logic                   I_PKT_ACK,
  input  wire logic                   I_EXPECT_ACK,
  input  wire logic                   I_LEN_VALID,
  input  wire logic [7:0]             I_LEN_DATA,
  input  wire logic                   I_LEN_ERR,
  input  wire logic                   I_PAYLOAD_BYTE,
  input  wire logic                   I_CRC_DONE,
  input  wire logic                   I_CRC_BAD,
  input  wire logic                   I_ZERO_SEED_CRC,
  input  wire logic                   I_END_OF_PACKET,
  input  wire logic                   I_CODE64,
  input  wire logic                   I_FRAMED,
  input  wire rxs_mode_type           I_DATA_MODE,
  // receive state seen by the rest of the device
  output logic                        O_RX_BUSY,
  output logic                        O_RX_ERR_EVT
);

  // ****************************************************************
  // address decode
  // ****************************************************************

  // the bank answers three offsets only; every other address reads as
  // zero and gets no acknowledge, so a host that probes the map can
  // tell a hole from a register that happens to hold zero
  //
  // writes to the three offsets are acknowledged but change nothing:
  // the host sees its access complete, while the receive side stays
  // the only writer of the bank
  //
  // true when the address names one of the three status registers
  function automatic logic reg_hit(input logic [`RXS_ADDR_W-1:0] addr);
    reg_hit = (addr == `RXS_OFS_STATUS) ||
              (addr == `RXS_OFS_COUNT)  ||
              (addr == `RXS_OFS_LENGTH);
  endfunction

  // ****************************************************************
  // receive sequence tracking
  // ****************************************************************

  // the receive side hands over single-cycle event pulses; this
  // sequence turns them into the load and clear strobes of the flags
  // and the counter
  //
  // idle: nothing in flight; only a start moves the sequence on
  // header: waiting for the length field, entered only when length
  //   handling is on; an end here is an early end
  // body: payload bytes are counted; an end before the checksum is
  //   an early end, the checksum result moves on to done
  // done: checksum seen, waiting for the closing end
  //
  // limitation: events that arrive out of order are not reported by
  // themselves; a length pulse outside the header and a checksum
  // pulse outside the body are dropped, so a broken receive side shows
  // up as a stale register value rather than a distinct flag
  //
  // trade-off: a start in any state restarts the sequence at once;
  // the previous packet's partial results are left as they stand, apart
  // from the early end flag and, without length handling, the count, which
  // are cleared; so the host must not read while the sequence is busy
  //
  rxs_state_type state_r;
  rxs_state_type state_nxt;
  logic          early_set;
  logic          len_load;
  logic [7:0]    len_value;
  logic          cnt_clear;
  logic          crc_load;
  logic          err_evt_nxt;

  // the sequence decides which end is early and when counts restart
  always_comb begin
    state_nxt   = state_r;
    early_set   = 1'b0;
    len_load    = 1'b0;
    len_value   = I_LEN_DATA;
    cnt_clear   = 1'b0;
    crc_load    = 1'b0;
    err_evt_nxt = 1'b0;
    case (state_r)
      RXS_IDLE: begin
        if (I_START_OF_PACKET) begin
          // without length handling the counter restarts at the start
          state_nxt = I_LEN_EN ? RXS_HDR : RXS_BODY;
          cnt_clear = !I_LEN_EN;
        end
      end
      RXS_HDR: begin
        if (I_END_OF_PACKET) begin
          state_nxt   = RXS_IDLE;
          early_set   = 1'b1;
          err_evt_nxt = 1'b1;
        end else if (I_LEN_VALID) begin
          state_nxt = RXS_BODY;
          len_load  = 1'b1;
          cnt_clear = 1'b1;
          // a damaged field is forced to zero except in GFSK mode,
          // and in every mode the packet is marked in error
          if (I_LEN_ERR) begin
            if (I_DATA_MODE != `RXS_MODE_GFSK) begin
              len_value = `RXS_LEN_ERR_VALUE;
            end
            early_set   = 1'b1;
            err_evt_nxt = 1'b1;
          end
        end
      end
      RXS_BODY: begin
        if (I_END_OF_PACKET) begin
          // an end before the checksum arrived cuts the packet short
          state_nxt   = RXS_IDLE;
          early_set   = 1'b1;
          err_evt_nxt = 1'b1;
        end else if (I_CRC_DONE) begin
          state_nxt   = RXS_DONE;
          crc_load    = 1'b1;
          err_evt_nxt = I_CRC_BAD;
        end
      end
      RXS_DONE: begin
        if (I_END_OF_PACKET) begin
          state_nxt = RXS_IDLE;
        end
      end
      default: begin
        state_nxt = RXS_IDLE;
      end
    endcase
    // a fresh start always restarts the sequence, even mid packet
    if (I_START_OF_PACKET && (state_r != RXS_IDLE)) begin
      state_nxt = I_LEN_EN ? RXS_HDR : RXS_BODY;
      cnt_clear = !I_LEN_EN;
      len_load  = 1'b0;
      crc_load  = 1'b0;
    end
    // type mismatch is a receive error as well
    if (I_TYPE_VALID && (I_PKT_ACK != I_EXPECT_ACK)) begin
      err_evt_nxt = 1'b1;
    end
  end

  // register stage for the sequence
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_r      <= RXS_IDLE;
      O_RX_ERR_EVT <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      O_RX_ERR_EVT <= err_evt_nxt;
    end
  end

  // busy in the header and body states only; the host waits for it to drop
  assign O_RX_BUSY = (state_r == RXS_HDR) || (state_r == RXS_BODY);

  // ****************************************************************
  // status flags and counters
  // ****************************************************************

  // the flags and the counters live in their own blocks so that each
  // keeps one next-value process and one register process
  //
  // the flags move on their own events, one field at a time; a read
  // taken while a packet is in flight may mix fields of two packets,
  // which is why the busy level is offered to the host
  //
  // the counter only counts while the body is being received; bytes
  // that arrive in the header or after the checksum are not payload
  //
  logic [7:0] status_val;
  logic [7:0] count_val;
  logic [7:0] length_val;

  // flags follow their own events, one at a time
  rxs_flags u_flags (
    .i_clk        (I_CLK),
    .i_rst        (I_RST),
    .i_sop        (I_START_OF_PACKET),
    .i_type_load  (I_TYPE_VALID),
    .i_pkt_ack    (I_PKT_ACK),
    .i_expect_ack (I_EXPECT_ACK),
    .i_early_set  (early_set),
    .i_crc_load   (crc_load),
    .i_crc_bad    (I_CRC_BAD),
    .i_zero_seed  (I_ZERO_SEED_CRC),
    .i_code64     (I_CODE64),
    .i_framed     (I_FRAMED),
    .i_mode       (I_DATA_MODE),
    .o_status     (status_val)
  );

  // payload bytes only count while the body is being received, so a
  // clean packet ends with count equal to the length field
  rxs_count u_count (
    .i_clk       (I_CLK),
    .i_rst       (I_RST),
    .i_clear     (cnt_clear),
    .i_byte      (I_PAYLOAD_BYTE && (state_r == RXS_BODY)),
    .i_len_load  (len_load),
    .i_len_value (len_value),
    .o_count     (count_val),
    .o_length    (length_val)
  );

  // ****************************************************************
  // register port
  // ****************************************************************

  // one access per strobe: the acknowledge and the read data appear
  // one clock after the strobe and the acknowledge stands one cycle
  //
  // the read data register holds its value until the next read, so a
  // host that samples late still sees the answer to its own read
  //
  // hazard: reads select a value and nothing else; no register of the
  // bank is cleared or advanced by being read, so a repeated read
  // always returns the same value while the receive side is quiet
  //
  logic [7:0] rdata_nxt;
  logic       ack_nxt;

  // reads only select a value; writes are acknowledged and dropped
  always_comb begin
    rdata_nxt = O_REG_RDATA;
    ack_nxt   = (I_REG_RD || I_REG_WR) && reg_hit(I_REG_ADDR);
    if (I_REG_RD) begin
      case (I_REG_ADDR)
        `RXS_OFS_STATUS: rdata_nxt = status_val;
        `RXS_OFS_COUNT:  rdata_nxt = count_val;
        `RXS_OFS_LENGTH: rdata_nxt = length_val;
        default:         rdata_nxt = `RXS_RDATA_NONE;
      endcase
    end
  end

  // read data is held until the next read
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_REG_RDATA <= `RXS_RDATA_NONE;
      O_REG_ACK   <= 1'b0;
    end else begin
      O_REG_RDATA <= rdata_nxt;
      O_REG_ACK   <= ack_nxt;
    end
  end

endmodule // rxs_regs
`default_nettype wire

// file: verification/rxs_monitor.sv
// assertion checker for the receive status register bank
`timescale 1ns/1ps
`default_nettype none
`include "rxs_defs.svh"
module rxs_monitor
  import rxs_pkg::*;
(
  input wire logic                   I_CLK,
  input wire logic                   I_RST,
  input wire logic [`RXS_ADDR_W-1:0] I_REG_ADDR,
  input wire logic                   I_REG_RD,
  input wire logic                   I_REG_WR,
  input wire logic [7:0]             O_REG_RDATA,
  input wire logic                   O_REG_ACK,
  input wire logic                   I_START_OF_PACKET,
  input wire logic                   I_END_OF_PACKET,
  input wire logic                   I_LEN_VALID,
  input wire logic                   I_CRC_DONE,
  input wire logic                   I_TYPE_VALID,
  input wire logic                   O_RX_BUSY,
  input wire logic                   O_RX_ERR_EVT
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);

  // request aimed at one of the three mapped registers
  wire logic hit = I_REG_ADDR inside
    {`RXS_OFS_STATUS, `RXS_OFS_COUNT, `RXS_OFS_LENGTH};

  a_ack_mapped: assert property ((I_REG_RD || I_REG_WR) && hit |=> O_REG_ACK)
    else $error("mapped access not acknowledged");
  a_ack_none: assert property (!((I_REG_RD || I_REG_WR) && hit) |=> !O_REG_ACK)
    else $error("acknowledge without mapped access");
  a_rdata_zero: assert property (I_REG_RD && !hit |=> O_REG_RDATA == 8'h00)
    else $error("unmapped read returned data");
  a_rdata_hold: assert property (!I_REG_RD |=> $stable(O_REG_RDATA))
    else $error("read data moved without a read");
  a_busy_start: assert property (I_START_OF_PACKET |=> O_RX_BUSY)
    else $error("start of packet did not raise busy");
  a_busy_idle: assert property (!O_RX_BUSY && !I_START_OF_PACKET |=> !O_RX_BUSY)
    else $error("busy rose without a start");
  a_err_early: assert property (I_END_OF_PACKET && O_RX_BUSY |=> O_RX_ERR_EVT)
    else $error("early end gave no error event");
  a_err_quiet: assert property (!(I_END_OF_PACKET || I_LEN_VALID || I_CRC_DONE
    || I_TYPE_VALID) |=> !O_RX_ERR_EVT)
    else $error("error event without a cause");
endmodule  // rxs_monitor
`default_nettype wire

// file: verification/rxs_host.sv
// host microcontroller model on the register port
`timescale 1ns/1ps
`default_nettype none
module rxs_host (
  input  wire logic  i_clk,
  input  wire logic  i_busy,
  output logic [5:0] o_addr,
  output logic       o_rd,
  output logic       o_wr,
  output logic [7:0] o_wdata
);
  int wait_n;

  // idle port; write data is not held, so show a non-zero pattern
  initial begin
    o_addr = 6'h3F;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 8'hA5;
  end

  // one access; results are only trusted once the receive is over
  task automatic xfer(input logic w, input logic [5:0] a,
                      input logic [7:0] d);
    wait_n = 0;
    while (i_busy === 1'b1 && wait_n < 200) begin
      @(posedge i_clk);
      wait_n++;
    end
    @(posedge i_clk);
    o_rd <= ~w;
    o_wr <= w;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
endmodule  // rxs_host
`default_nettype wire

// file: verification/tb.sv
// self-checking bench for the receive status register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rst;
  logic [5:0]  ev;
  logic        len_en, p_ack, x_ack, len_err, bad, zs, c64, frm;
  logic [7:0]  len, wdata, rdata;
  logic [1:0]  mode, lm;
  logic [5:0]  addr;
  logic        rd, wr, ack, busy, eflag;
  logic [8:0]  exp_q[$];
  logic [8:0]  got, want;
  logic [2:0]  gd;
  logic        rd_seen = 1'b0;
  logic [31:0] r;
  integer      seed;
  int          err_total, compares, n;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  rxs_regs DUT (
    .I_CLK(clk), .I_RST(rst), .I_REG_ADDR(addr), .I_REG_RD(rd),
    .I_REG_WR(wr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
    .O_REG_ACK(ack), .I_LEN_EN(len_en), .I_START_OF_PACKET(ev[0]),
    .I_TYPE_VALID(ev[1]), .I_PKT_ACK(p_ack), .I_EXPECT_ACK(x_ack),
    .I_LEN_VALID(ev[2]), .I_LEN_DATA(len), .I_LEN_ERR(len_err),
    .I_PAYLOAD_BYTE(ev[3]), .I_CRC_DONE(ev[4]), .I_CRC_BAD(bad),
    .I_ZERO_SEED_CRC(zs), .I_END_OF_PACKET(ev[5]), .I_CODE64(c64),
    .I_FRAMED(frm), .I_DATA_MODE(mode), .O_RX_BUSY(busy),
    .O_RX_ERR_EVT(eflag));
  rxs_host host (.i_clk(clk), .i_busy(busy), .o_addr(addr), .o_rd(rd),
    .o_wr(wr), .o_wdata(wdata));

  // a read answers one cycle later; pair it with the oldest note
  always @(posedge clk) begin
    if (rd_seen && exp_q.size() > 0) begin
      got = {ack, rdata};
      want = exp_q.pop_front();
      compares++;
      if (got !== want) begin
        err_total++;
        $display("CHECK FAILED t=%0t got=%h want=%h", $time, got, want);
      end
    end
    rd_seen <= rd;
  end

  // one cycle of receive event pulses
  task automatic step(input logic [5:0] e);
    @(posedge clk);
    ev <= e;
  endtask

  // start, type plus length, payload, crc, end
  task automatic pkt(input int k, input logic early);
    step(6'h01);
    step(6'h06);
    repeat (k) step(6'h08);
    if (!early) step(6'h10);
    step(6'h20);
    step(6'h00);
  endtask

  // note the expected {ack, data} before asking the host to read
  task automatic chk(input logic [5:0] a, input logic [8:0] w);
    exp_q.push_back(w);
    host.xfer(1'b0, a, 8'h00);
  endtask

  task automatic close_out;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // cut a hang short far beyond the fewer than 200 cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out();
  end

  initial begin
    seed = 82401;
    err_total = 0;
    compares = 0;
    rst = 1'b1;
    ev = 6'h00;
    {len_en, p_ack, x_ack, len_err, bad, zs, c64, frm} = 8'h83;
    len = 8'h08;
    mode = 2'h1;
    lm = 2'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk(6'h08, 9'h100);
    chk(6'h09, 9'h100);
    chk(6'h0A, 9'h100);
    chk(6'h0B, 9'h000);
    // end arrives after three of eight bytes; writes must not stick
    pkt(3, 1'b1);
    host.xfer(1'b1, 6'h08, 8'hFF);
    host.xfer(1'b1, 6'h09, 8'hFF);
    chk(6'h08, 9'h120);
    chk(6'h09, 9'h103);
    // good packets over modes 0 to 2, random type, seed, code, framing
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      r = $random(seed);
      n = 1 + r[6:4];
      {p_ack, x_ack, zs, c64, frm} <= r[4:0];
      mode <= 2'(i % 3);
      len <= 8'(n);
      pkt(n, 1'b0);
      lm = frm ? mode : lm;
      chk(6'h08, {1'b1, p_ack, p_ack ^ x_ack, 1'b0, zs, 1'b0, c64, lm});
      chk(6'h09, {1'b1, 8'(n)});
      chk(6'h0A, {1'b1, 8'(n)});
    end
    // failed crc keeps code and mode of the last good packet
    @(posedge clk);
    gd = {c64, lm};
    {c64, bad, frm} <= {~c64, 2'b11};
    mode <= ~lm;
    pkt(2, 1'b0);
    chk(6'h08, {1'b1, p_ack, p_ack ^ x_ack, 1'b0, zs, 1'b1, gd});
    // bad length field: zeroed except at the GFSK rate
    @(posedge clk);
    {bad, len_err} <= 2'b01;
    mode <= 2'h1;
    len <= 8'h33;
    pkt(0, 1'b1);
    chk(6'h0A, 9'h100);
    @(posedge clk);
    mode <= 2'h0;
    pkt(0, 1'b1);
    chk(6'h0A, 9'h133);
    // without length handling the count restarts at the start
    @(posedge clk);
    {len_en, len_err} <= 2'b00;
    pkt(2, 1'b0);
    chk(6'h09, 9'h102);
    repeat (3) @(posedge clk);
    close_out();
  end
endmodule  // tb

bind rxs_regs rxs_monitor u_mon (.I_CLK(I_CLK), .I_RST(I_RST),
  .I_REG_ADDR(I_REG_ADDR), .I_REG_RD(I_REG_RD), .I_REG_WR(I_REG_WR),
  .O_REG_RDATA(O_REG_RDATA), .O_REG_ACK(O_REG_ACK),
  .I_START_OF_PACKET(I_START_OF_PACKET), .I_END_OF_PACKET(I_END_OF_PACKET),
  .I_LEN_VALID(I_LEN_VALID), .I_CRC_DONE(I_CRC_DONE),
  .I_TYPE_VALID(I_TYPE_VALID), .O_RX_BUSY(O_RX_BUSY),
  .O_RX_ERR_EVT(O_RX_ERR_EVT));
`default_nettype wire
